// File: hdl/bpl_cfg.svh
`ifndef BPL_CFG_SVH
`define BPL_CFG_SVH

// port count and width
`define BPL_NUM_PORTS 6
`define BPL_PORT_W 8
// latch reset values per port, index 0..5
`define BPL_RST_PORT_ZERO 8'hFF
`define BPL_RST_PORT_ONE 8'h00
`define BPL_RST_PORT_TWO 8'h00
`define BPL_RST_PORT_THREE 8'hFF
`define BPL_RST_PORT_FOUR 8'h00
`define BPL_RST_PORT_FIVE 8'h00
// port indices with special behaviour
`define BPL_IDX_ZERO 3'h0
`define BPL_IDX_TWO 3'h2
`define BPL_IDX_THREE 3'h3
// alternate strobe positions on port three
`define BPL_PORT_THREE_RD_BIT 7
`define BPL_PORT_THREE_WR_BIT 6
// machine-cycle state holding the pull-up boost; the buffer updates in every phase one
`define BPL_STATE_ONE 3'h1
// synchroniser depth
`define BPL_SYNC_STAGES 2

`endif

// File: hdl/bpl_pkg.sv
package bpl_pkg;
  // bit-level read-modify-write operations on one latch bit
  typedef enum logic [1:0] {
    BPL_BIT_NONE,
    BPL_BIT_MOVE,
    BPL_BIT_CLEAR,
    BPL_BIT_SET
  } bpl_bit_op_type;

  // oscillator phase within a state
  typedef enum logic {
    BPL_PHASE_ONE,
    BPL_PHASE_TWO
  } bpl_phase_type;
endpackage

// File: hdl/bpl_pin_if.sv
`timescale 1ns/1ns
// raw pin levels in, synchronised levels out
interface bpl_pin_if #(
  parameter int WIDTH = 48
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync_mp (input raw, output synced);
  modport core_mp (output raw, input synced);
endinterface

// File: hdl/bpl_sync.sv
`timescale 1ns/1ns
`include "bpl_cfg.svh"
// two-flop synchroniser bank; first stage is read only by the second
module bpl_sync
  import bpl_pkg::*;
#(
  parameter int WIDTH = 48
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bpl_pin_if.sync_mp pins
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // reset to ones: an idle quasi-bidirectional pin floats high
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= pins.raw;
      sync_r <= meta_r;
    end
  end

  assign pins.synced = sync_r;
endmodule

// File: hdl/bpl_ports.sv
// Function
// - six bidirectional ports, each a latch, output driver and input path.
// - alternate output only reaches the pin when the latch bit holds one.
// - ports one to five follow alternate output; pin always feeds alternate input.
// - latch loads on write strobe; read-latch returns latch, read-pin returns pin.
// - read-modify-write instructions read the latch, never the pin.
// - bit move, clear, set rewrite the whole latch byte, one bit changed.
// - external access: port zero muxes low address/data, port two high address.
// - external access keeps port two latch, loads port zero latch with ones.
// - reset clears latches of ports one, two, four and five.
// - reset sets latches of ports zero and three to all ones.
// - port zero pulls up only for bus ones, else open drain.
// - latch written at state six phase two; pin updates at state one phase one.
// - zero-to-one on ports one to five boosts pull-up for state one phases.
// - program strobe for code fetch; port three bits seven/six carry read/write.
`timescale 1ns/1ns
`include "bpl_cfg.svh"
module bpl_ports
  import bpl_pkg::*;
#(
  parameter int NUM_PORTS = `BPL_NUM_PORTS,
  parameter int PORT_W = `BPL_PORT_W
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // machine-cycle timing from the core
  input wire logic [2:0] mc_state_i,
  input wire bpl_phase_type phase_i,
  // cpu write side, one-cycle strobe given in the state six phase two cycle
  input wire logic wr_latch_i,
  input wire logic [2:0] wr_port_i,
  input wire logic [PORT_W-1:0] wr_data_i,
  input wire bpl_bit_op_type wr_bit_op_i,
  input wire logic [2:0] wr_bit_idx_i,
  input wire logic wr_bit_val_i,
  // cpu read side
  input wire logic rd_latch_i,
  input wire logic rd_pin_i,
  input wire logic rd_rmw_i,
  input wire logic [2:0] rd_port_i,
  output logic [PORT_W-1:0] rd_data_o,
  output logic rd_valid_o,
  // external memory bus control from the core
  input wire logic ext_acc_i,
  input wire logic ext_addr_phase_i,
  input wire logic ext_wide_addr_i,
  input wire logic ext_drive_data_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [PORT_W-1:0] ext_wdata_i,
  input wire logic ext_code_rd_i,
  input wire logic ext_data_rd_i,
  input wire logic ext_data_wr_i,
  output logic [PORT_W-1:0] ext_rdata_o,
  output logic program_store_strobe_n_o,
  // peripheral alternate functions, bit 8*p+b is port p bit b
  input wire logic [NUM_PORTS*PORT_W-1:0] alt_out_i,
  output logic [NUM_PORTS*PORT_W-1:0] alt_in_o,
  // pins
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_i,
  output logic [NUM_PORTS*PORT_W-1:0] pin_o,
  output logic [NUM_PORTS*PORT_W-1:0] pin_oe_o,
  output logic [NUM_PORTS*PORT_W-1:0] boost_o
);
  localparam int TOTAL_W = NUM_PORTS * PORT_W;
  localparam int RD_STROBE_BIT = 3 * PORT_W + `BPL_PORT_THREE_RD_BIT;
  localparam int WR_STROBE_BIT = 3 * PORT_W + `BPL_PORT_THREE_WR_BIT;

  // pick one port byte out of a flat vector
  function automatic logic [PORT_W-1:0] port_byte(input logic [TOTAL_W-1:0] vec,
                                                  input logic [2:0] idx);
    port_byte = vec[idx*PORT_W +: PORT_W];
  endfunction

  // byte written back by a plain write or a single-bit operation
  function automatic logic [PORT_W-1:0] merge_byte(input logic [PORT_W-1:0] old,
                                                   input logic [PORT_W-1:0] data,
                                                   input bpl_bit_op_type op,
                                                   input logic [2:0] idx,
                                                   input logic val);
    logic [PORT_W-1:0] res;
    res = old;
    case (op)
      BPL_BIT_NONE: res = data;
      BPL_BIT_MOVE: res[idx] = val;
      BPL_BIT_CLEAR: res[idx] = 1'b0;
      BPL_BIT_SET: res[idx] = 1'b1;
      default: res = old;
    endcase
    merge_byte = res;
  endfunction

  bpl_pin_if #(.WIDTH(TOTAL_W)) pins ();

  bpl_sync #(
    .WIDTH(TOTAL_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pins(pins.sync_mp)
  );

  assign pins.raw = pin_i;

  logic [TOTAL_W-1:0] latch_r;
  logic [TOTAL_W-1:0] latch_nxt;
  logic [TOTAL_W-1:0] buf_r;
  logic [TOTAL_W-1:0] buf_nxt;
  logic [TOTAL_W-1:0] boost_r;
  logic [TOTAL_W-1:0] boost_nxt;
  logic [TOTAL_W-1:0] rst_val;
  logic [TOTAL_W-1:0] quasi_mask;
  logic [TOTAL_W-1:0] alt_eff;
  logic [PORT_W-1:0] rd_data_r;
  logic [PORT_W-1:0] rd_data_nxt;
  logic rd_valid_r;
  logic [PORT_W-1:0] ext_rdata_r;
  logic code_strobe_n_r;

  // reset values and the mask of ports with pull-ups, one byte per port
  assign rst_val = {`BPL_RST_PORT_FIVE, `BPL_RST_PORT_FOUR, `BPL_RST_PORT_THREE,
                    `BPL_RST_PORT_TWO, `BPL_RST_PORT_ONE, `BPL_RST_PORT_ZERO};
  assign quasi_mask = {{(TOTAL_W-PORT_W){1'b1}}, {PORT_W{1'b0}}};

  // read/write strobes for external data ride on port three alternate outputs
  always_comb begin
    alt_eff = alt_out_i;
    alt_eff[RD_STROBE_BIT] = alt_out_i[RD_STROBE_BIT] & ~ext_data_rd_i;
    alt_eff[WR_STROBE_BIT] = alt_out_i[WR_STROBE_BIT] & ~ext_data_wr_i;
  end

  // per-port latch next value: bus access forces port zero to ones
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_latch
      logic hit;
      logic [PORT_W-1:0] cur;
      assign cur = latch_r[gp*PORT_W +: PORT_W];
      assign hit = wr_latch_i && (wr_port_i == 3'(gp));
      if (gp == 0) begin : g_zero
        assign latch_nxt[gp*PORT_W +: PORT_W] = ext_acc_i ? {PORT_W{1'b1}} :
          hit ? merge_byte(cur, wr_data_i, wr_bit_op_i, wr_bit_idx_i, wr_bit_val_i) : cur;
      end else begin : g_other
        // port two is never touched by a bus access
        assign latch_nxt[gp*PORT_W +: PORT_W] = hit ?
          merge_byte(cur, wr_data_i, wr_bit_op_i, wr_bit_idx_i, wr_bit_val_i) : cur;
      end
    end
  endgenerate

  // output buffers sample the latch only in phase one and hold through phase two
  assign buf_nxt = (phase_i == BPL_PHASE_ONE) ? latch_r : buf_r;

  // boost the pull-up in state one for bits that rise as the buffer takes them;
  // it spans phase one and phase two, two oscillator periods
  assign boost_nxt = (mc_state_i != `BPL_STATE_ONE) ? '0 :
                     (phase_i == BPL_PHASE_ONE) ? (latch_r & ~buf_r & quasi_mask) :
                     boost_r;

  // latch read for read-latch and for any read-modify-write, else the pin
  assign rd_data_nxt = (rd_latch_i || (rd_pin_i && rd_rmw_i)) ?
                       port_byte(latch_r, rd_port_i) :
                       port_byte(pins.synced, rd_port_i);

  // latches, buffers and boost; latch writes land at state six phase two
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      latch_r <= rst_val;
      buf_r <= rst_val;
      boost_r <= '0;
    end else begin
      latch_r <= latch_nxt;
      buf_r <= buf_nxt;
      boost_r <= boost_nxt;
    end
  end

  // read data and bus capture are registered
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
      ext_rdata_r <= '0;
      code_strobe_n_r <= 1'b1;
    end else begin
      rd_valid_r <= rd_latch_i | rd_pin_i;
      if (rd_latch_i || rd_pin_i) begin
        rd_data_r <= rd_data_nxt;
      end
      if (ext_acc_i && !ext_drive_data_i && !ext_addr_phase_i) begin
        ext_rdata_r <= port_byte(pins.synced, `BPL_IDX_ZERO);
      end
      code_strobe_n_r <= ~ext_code_rd_i;
    end
  end

  // port zero: address then data on the bus, else open drain from the buffer
  logic [PORT_W-1:0] addr_bus_val;
  logic addr_bus_drive;
  assign addr_bus_val = ext_addr_phase_i ? ext_addr_i[7:0] : ext_wdata_i;
  assign addr_bus_drive = ext_acc_i && (ext_addr_phase_i || ext_drive_data_i);
  assign pin_o[PORT_W-1:0] = addr_bus_drive ? addr_bus_val : {PORT_W{1'b0}};
  // both drivers active for bus address or write data, none on bus reads; a latched one floats otherwise
  assign pin_oe_o[PORT_W-1:0] = addr_bus_drive ? {PORT_W{1'b1}} :
                                ext_acc_i ? {PORT_W{1'b0}} : ~buf_r[PORT_W-1:0];

  // ports one to five: quasi-bidirectional, latch gates alternate output
  generate
    for (gp = 1; gp < NUM_PORTS; gp++) begin : g_quasi
      logic [PORT_W-1:0] lvl;
      logic [PORT_W-1:0] gated;
      assign gated = buf_r[gp*PORT_W +: PORT_W] & alt_eff[gp*PORT_W +: PORT_W];
      if (gp == 2) begin : g_two
        // wide address overrides the port two contents for the cycle
        assign lvl = (ext_acc_i && ext_wide_addr_i) ? ext_addr_i[15:8] : gated;
      end else begin : g_plain
        assign lvl = gated;
      end
      assign pin_o[gp*PORT_W +: PORT_W] = lvl;
      // drive when pulling low, boosting or carrying the port two wide address; a plain one is left to the pull-up
      assign pin_oe_o[gp*PORT_W +: PORT_W] = ~lvl | boost_r[gp*PORT_W +: PORT_W] |
        ((gp == 2 && ext_acc_i && ext_wide_addr_i) ? {PORT_W{1'b1}} : {PORT_W{1'b0}});
    end
  endgenerate

  assign alt_in_o = pins.synced;
  assign boost_o = boost_r;
  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign ext_rdata_o = ext_rdata_r;
  assign program_store_strobe_n_o = code_strobe_n_r;
endmodule

// File: sim/bpl_ports_assertions.sv
`timescale 1ns/1ns
// watches the port block from its pins only
module bpl_ports_assertions (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rd_latch_i,
  input wire logic rd_pin_i,
  input wire logic rd_valid_o,
  input wire logic ext_acc_i,
  input wire logic ext_addr_phase_i,
  input wire logic ext_wide_addr_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic ext_code_rd_i,
  input wire logic ext_data_rd_i,
  input wire logic program_store_strobe_n_o,
  input wire logic [47:0] pin_i,
  input wire logic [47:0] alt_in_o,
  input wire logic [47:0] pin_o,
  input wire logic [47:0] pin_oe_o,
  input wire logic [47:0] boost_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // bus conditions must hold two edges so a registered driver still counts
  a_rd_answer: assert property (rd_valid_o == $past(rd_latch_i || rd_pin_i))
    else $error("read strobe not answered in one cycle");
  a_quasi_low: assert property ((~pin_o[47:8] & ~pin_oe_o[47:8]) == 40'h00_0000_0000)
    else $error("quasi pin low without drive");
  a_bus_low_addr: assert property ((ext_acc_i && ext_addr_phase_i) [*2] |->
    pin_oe_o[7:0] == 8'hFF && pin_o[7:0] == ext_addr_i[7:0])
    else $error("port zero not driving low address");
  a_bus_high_addr: assert property ((ext_acc_i && ext_wide_addr_i) [*2] |->
    pin_o[23:16] == ext_addr_i[15:8]) else $error("port two not driving high address");
  a_code_strobe: assert property (program_store_strobe_n_o == !$past(ext_code_rd_i))
    else $error("program strobe does not follow fetch");
  a_rd_strobe: assert property (ext_data_rd_i [*2] |-> !pin_o[31])
    else $error("read strobe not low on port three");
  a_sync_in: assert property ($past(rst_n_i) && $past(rst_n_i, 2) |->
    alt_in_o == $past(pin_i, 2)) else $error("alternate input not two-flop pin");
  a_boost_len: assert property ($rose(boost_o[32]) |=> boost_o[32] ##1 !boost_o[32])
    else $error("boost not two cycles");
endmodule

bind bpl_ports bpl_ports_assertions bpl_ports_assertions_inst (.core_clk_i, .rst_n_i,
  .rd_latch_i, .rd_pin_i, .rd_valid_o, .ext_acc_i, .ext_addr_phase_i, .ext_wide_addr_i,
  .ext_addr_i, .ext_code_rd_i, .ext_data_rd_i, .program_store_strobe_n_o, .pin_i, .alt_in_o,
  .pin_o, .pin_oe_o, .boost_o);

// File: sim/bpl_pin_model.sv
`timescale 1ns/1ns
// board side of the pins: pull-ups on ports one to five, port zero floats
module bpl_pin_model (
  input wire logic core_clk_i,
  input wire logic [47:0] pin_o_i,
  input wire logic [47:0] pin_oe_i,
  input wire logic [47:0] ext_oe_i,
  input wire logic [47:0] ext_val_i,
  output logic [47:0] lvl_o
);
  logic [7:0] flt_r = 8'h00;
  logic [47:0] rel_w;
  // a floating line toggles so a stale level is never read back as valid
  always_ff @(posedge core_clk_i) flt_r <= ~flt_r;
  // device drive first, then external drive, then released level
  assign rel_w = {40'hFF_FFFF_FFFF, flt_r};
  assign lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_oe_i & ext_val_i) |
    (~pin_oe_i & ~ext_oe_i & rel_w);
endmodule

// File: sim/tb_bpl_ports.sv
`timescale 1ns/1ns
module tb_bpl_ports
  import bpl_pkg::*;
;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_latch_i = 1'b0, wr_bit_val_i = 1'b0;
  logic rd_latch_i = 1'b0, rd_pin_i = 1'b0, rd_rmw_i = 1'b0, ext_acc_i = 1'b0;
  logic ext_addr_phase_i = 1'b0, ext_wide_addr_i = 1'b0, ext_drive_data_i = 1'b0;
  logic ext_code_rd_i = 1'b0, ext_data_rd_i = 1'b0, ext_data_wr_i = 1'b0;
  logic [2:0] mc_state_i = 3'h1, wr_port_i = 3'h0, wr_bit_idx_i = 3'h0, rd_port_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00, ext_wdata_i = 8'h00, rd_data_o, ext_rdata_o, d;
  logic [15:0] ext_addr_i = 16'h0000;
  logic [47:0] alt_out_i = 48'hFFFF_FFFF_FFFF, ext_oe = 48'h0, ext_val = 48'h0;
  logic [47:0] pin_i, alt_in_o, pin_o, pin_oe_o, boost_o;
  logic rd_valid_o, program_store_strobe_n_o;
  bpl_phase_type phase_i = BPL_PHASE_ONE;
  bpl_bit_op_type wr_bit_op_i = BPL_BIT_NONE;
  int n_errors = 0, total_checks = 0;
  bpl_ports bpl_ports_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mc_state_i(mc_state_i),
    .phase_i(phase_i), .wr_latch_i(wr_latch_i), .wr_port_i(wr_port_i), .wr_data_i(wr_data_i),
    .wr_bit_op_i(wr_bit_op_i), .wr_bit_idx_i(wr_bit_idx_i), .wr_bit_val_i(wr_bit_val_i),
    .rd_latch_i(rd_latch_i), .rd_pin_i(rd_pin_i), .rd_rmw_i(rd_rmw_i), .rd_port_i(rd_port_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .ext_acc_i(ext_acc_i),
    .ext_addr_phase_i(ext_addr_phase_i), .ext_wide_addr_i(ext_wide_addr_i),
    .ext_drive_data_i(ext_drive_data_i), .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i),
    .ext_code_rd_i(ext_code_rd_i), .ext_data_rd_i(ext_data_rd_i),
    .ext_data_wr_i(ext_data_wr_i), .ext_rdata_o(ext_rdata_o),
    .program_store_strobe_n_o(program_store_strobe_n_o), .alt_out_i(alt_out_i),
    .alt_in_o(alt_in_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .boost_o(boost_o));
  bpl_pin_model bpl_pin_model_inst (.core_clk_i(core_clk_i), .pin_o_i(pin_o),
    .pin_oe_i(pin_oe_o), .ext_oe_i(ext_oe), .ext_val_i(ext_val), .lvl_o(pin_i));
  always #2 core_clk_i = ~core_clk_i;
  // machine-cycle sequencer: two phases per state, six states
  always @(negedge core_clk_i) begin
    phase_i <= (phase_i == BPL_PHASE_ONE) ? BPL_PHASE_TWO : BPL_PHASE_ONE;
    if (phase_i == BPL_PHASE_TWO) mc_state_i <= (mc_state_i == 3'h6) ? 3'h1 : mc_state_i + 3'h1;
  end
  task close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // write strobe lands in the state six phase two cycle only
  task wr(input logic [2:0] p, input logic [7:0] v, input bpl_bit_op_type op, input logic [2:0] b);
    int i;
    i = 0;
    while (!(mc_state_i == 3'h6 && phase_i == BPL_PHASE_ONE)) begin
      i++;
      if (i > 24) begin
        n_errors++;
        close_out;
      end
      @(negedge core_clk_i);
    end
    wr_latch_i <= 1'b1;
    wr_port_i <= p;
    wr_data_i <= v;
    wr_bit_op_i <= op;
    wr_bit_idx_i <= b;
    wr_bit_val_i <= v[0];
    @(negedge core_clk_i);
    wr_latch_i <= 1'b0;
  endtask
  // one read pulse; answer stands one cycle later
  task rd(input logic [2:0] p, input logic pn, input logic rmw);
    rd_latch_i <= ~pn;
    rd_pin_i <= pn;
    rd_rmw_i <= rmw;
    rd_port_i <= p;
    @(negedge core_clk_i);
    rd_latch_i <= 1'b0;
    rd_pin_i <= 1'b0;
    chk({47'h0, rd_valid_o}, 48'h1);
    d = rd_data_o;
    @(negedge core_clk_i);
  endtask
  task t_reset;
    logic [7:0] rv [6];
    rv = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    chk(pin_oe_o & 48'hFFFF_00FF_FFFF, 48'hFFFF_00FF_FF00);
    for (int p = 0; p < 6; p++) begin
      rd(p[2:0], 1'b0, 1'b0);
      chk({40'h0, d}, {40'h0, rv[p]});
    end
  endtask
  task t_rw;
    wr(3'h1, 8'hA5, BPL_BIT_NONE, 3'h0);
    chk(pin_i[15:8], 8'h00);
    cyc(1);
    chk(pin_i[15:8], 8'hA5);
    ext_oe[8] <= 1'b1;
    // boost holds the pin high two more edges, then two synchroniser stages
    cyc(4);
    rd(3'h1, 1'b1, 1'b0);
    chk({40'h0, d}, 48'hA4);
    rd(3'h1, 1'b1, 1'b1);
    chk({40'h0, d}, 48'hA5);
    ext_oe[8] <= 1'b0;
  endtask
  // set, clear and two moves keep every other latch bit
  task t_bits;
    bpl_bit_op_type op [4];
    logic [2:0] bi [4];
    logic [7:0] ex [4];
    op = '{BPL_BIT_SET, BPL_BIT_CLEAR, BPL_BIT_MOVE, BPL_BIT_MOVE};
    bi = '{3'h1, 3'h0, 3'h7, 3'h3};
    ex = '{8'hA7, 8'hA6, 8'h26, 8'h2E};
    for (int k = 0; k < 4; k++) begin
      wr(3'h1, {7'h0, k[0]}, op[k], bi[k]);
      rd(3'h1, 1'b0, 1'b0);
      chk({40'h0, d}, {40'h0, ex[k]});
    end
  endtask
  task t_alt;
    alt_out_i[9] <= 1'b0;
    cyc(4);
    chk(pin_i[15:8], 8'h2C);
    chk(alt_in_o[15:8], 8'h2C);
    alt_out_i[9] <= 1'b1;
  endtask
  task t_boost;
    wr(3'h4, 8'hFF, BPL_BIT_NONE, 3'h0);
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      chk(boost_o, (k < 2) ? 48'h00FF_0000_0000 : 48'h0);
    end
  endtask
  // software keeps off ports zero and two while the bus runs
  task t_ext;
    wr(3'h0, 8'h00, BPL_BIT_NONE, 3'h0);
    wr(3'h2, 8'h5A, BPL_BIT_NONE, 3'h0);
    ext_acc_i <= 1'b1;
    ext_wide_addr_i <= 1'b1;
    ext_addr_phase_i <= 1'b1;
    ext_addr_i <= 16'hC33C;
    ext_code_rd_i <= 1'b1;
    cyc(2);
    chk({pin_i[23:16], pin_i[7:0], 7'h0, program_store_strobe_n_o}, 24'hC33C00);
    d = pin_i[7:0];
    ext_addr_phase_i <= 1'b0;
    ext_code_rd_i <= 1'b0;
    ext_data_rd_i <= 1'b1;
    ext_oe[7:0] <= 8'hFF;
    ext_val[7:0] <= 8'h96;
    // capture sees the pin only after two synchroniser stages
    cyc(3);
    chk({ext_rdata_o, 7'h0, pin_i[31]}, 16'h9600);
    chk({40'h0, d}, 48'h3C);
    ext_data_rd_i <= 1'b0;
    ext_oe[7:0] <= 8'h00;
    ext_drive_data_i <= 1'b1;
    ext_data_wr_i <= 1'b1;
    ext_wdata_i <= 8'h69;
    cyc(2);
    chk({pin_i[7:0], 7'h0, pin_i[30]}, 16'h6900);
    ext_acc_i <= 1'b0;
    ext_drive_data_i <= 1'b0;
    ext_data_wr_i <= 1'b0;
    cyc(3);
    rd(3'h0, 1'b0, 1'b0);
    chk({40'h0, d}, 48'hFF);
    rd(3'h2, 1'b0, 1'b0);
    chk({pin_i[23:16], d}, 16'h5A5A);
  endtask
  initial begin
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(1);
    t_reset;
    t_rw;
    t_bits;
    t_alt;
    t_boost;
    t_ext;
    close_out;
  end
endmodule
